// ---- core/pfcl_map.vh ----
// Register offsets, field positions, reset values and mode codes of the pixel format and colour look-up block
`ifndef PFCL_MAP_VH
`define PFCL_MAP_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
// Printed offsets are word indices; the byte address is four times the index
`define PFCL_PANEL_CFG_IDX 10'h030
`define PFCL_DISP_MODE_IDX 10'h041
`define PFCL_PANEL_CFG_ADDR ({`PFCL_PANEL_CFG_IDX, 2'h0})
`define PFCL_DISP_MODE_ADDR ({`PFCL_DISP_MODE_IDX, 2'h0})
`define PFCL_FMT_ADDR 12'h200
`define PFCL_LUT_SEL_ADDR 12'h204
`define PFCL_LUT_IDX_ADDR 12'h208
`define PFCL_LUT_DATA_ADDR 12'h20C
`define PFCL_BUF_ADDR_ADDR 12'h210
`define PFCL_BUF_DATA_ADDR 12'h214
`define PFCL_STATUS_ADDR 12'h218

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFCL_COLOR_BIT 2
`define PFCL_DITHER_BIT 1
`define PFCL_ENABLE_BIT 0
`define PFCL_DEPTH_LSB 0
`define PFCL_PANEL_LSB 2
`define PFCL_LUT_CRT_BIT 0

// ----------------------------------------
// Mode codes and reset values
// ----------------------------------------
`define PFCL_DEPTH_4 2'h0
`define PFCL_DEPTH_8 2'h1
`define PFCL_DEPTH_15 2'h2
`define PFCL_DEPTH_16 2'h3
`define PFCL_PANEL_PASSIVE 2'h0
`define PFCL_PANEL_ACTIVE 2'h1
`define PFCL_PANEL_CRT 2'h2
`define PFCL_FMT_RESET 8'h00
`define PFCL_CFG_RESET 8'h00
`define PFCL_BUF_SMALL_KB 512
`define PFCL_BUF_LARGE_KB 2048

`endif

// ---- core/pfcl_lut.v ----
// Colour look-up table, 256 entries of 4-bit red, green and blue
`timescale 1ns/1ns
module pfcl_lut #(
    parameter ENTRIES = 256,
    parameter IW = 8
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Write port
    input wire wr_en,
    input wire [IW-1:0] wr_idx,
    input wire [11:0] wr_rgb,
    // Read ports
    input wire [IW-1:0] rd_idx,
    output wire [11:0] rd_rgb,
    input wire [IW-1:0] sw_idx,
    output wire [11:0] sw_rgb
);
    reg [11:0] mem [0:ENTRIES-1];
    integer i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < ENTRIES; i = i + 1) begin
                mem[i] <= 12'h000;
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_rgb;
        end
    end

    assign rd_rgb = mem[rd_idx];
    assign sw_rgb = mem[sw_idx];
endmodule

// ---- core/pfcl_top.v ----
// Pixel unpacking, colour look-up and depth limiting, with APB register access
`timescale 1ns/1ns
`include "pfcl_map.vh"
module pfcl_top #(
    parameter BUF_AW = 19,
    parameter LUT_IW = 8
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Display buffer read port, one byte per request
    output reg [BUF_AW-1:0] fetch_addr,
    output reg fetch_req,
    input wire [7:0] fetch_data,
    input wire fetch_valid,
    // Pixel timing
    input wire pix_ready,
    // Pixel outputs toward modulator, LCD and CRT
    output reg pix_valid,
    output reg [5:0] lcd_red,
    output reg [5:0] lcd_green,
    output reg [5:0] lcd_blue,
    output reg [5:0] crt_red,
    output reg [5:0] crt_green,
    output reg [5:0] crt_blue,
    output reg lut_bypass,
    output reg pix_mono
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] panel_cfg;
    reg [7:0] disp_mode;
    reg [7:0] fmt;
    reg [1:0] lut_sel;
    reg [LUT_IW-1:0] lut_idx;
    reg [1:0] lut_bank;
    reg [7:0] lut_red;
    reg [7:0] lut_green;
    reg [BUF_AW-1:0] host_addr;
    reg [7:0] host_wdata;
    reg host_wr;
    // Host buffer store, small so it is a staging window
    reg [7:0] mem_host [0:3];

    wire [1:0] depth = fmt[`PFCL_DEPTH_LSB +: 2];
    wire [1:0] panel = fmt[`PFCL_PANEL_LSB +: 2];
    wire enable = disp_mode[`PFCL_ENABLE_BIT];
    wire color = panel_cfg[`PFCL_COLOR_BIT];
    wire dither = disp_mode[`PFCL_DITHER_BIT];

    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;

    function known_addr;
        input [11:0] a;
        begin
            known_addr = (a == `PFCL_PANEL_CFG_ADDR) || (a == `PFCL_DISP_MODE_ADDR) ||
                (a == `PFCL_FMT_ADDR) || (a == `PFCL_LUT_SEL_ADDR) || (a == `PFCL_LUT_IDX_ADDR) ||
                (a == `PFCL_LUT_DATA_ADDR) || (a == `PFCL_BUF_ADDR_ADDR) ||
                (a == `PFCL_BUF_DATA_ADDR) || (a == `PFCL_STATUS_ADDR);
        end
    endfunction

    // Widen a primary to 6 bits, MSB-aligned
    function [5:0] widen4;
        input [3:0] v;
        begin
            widen4 = {v, v[3:2]};
        end
    endfunction

    function [5:0] widen5;
        input [4:0] v;
        begin
            widen5 = {v, v[4]};
        end
    endfunction

    // Passive panel without dithering keeps only the four MSBs
    function [5:0] limit;
        input [5:0] v;
        input cut;
        begin
            limit = cut ? {v[5:2], v[5:4]} : v;
        end
    endfunction

    // ----------------------------------------
    // LUT instances, one per output
    // ----------------------------------------
    reg [LUT_IW-1:0] pix_idx;
    wire [11:0] lcd_rgb;
    wire [11:0] crt_rgb;
    wire [11:0] lcd_sw_rgb;
    wire [11:0] crt_sw_rgb;
    wire lut_data_wr = wr_acc && (paddr == `PFCL_LUT_DATA_ADDR) && (lut_bank == 2'h2);
    wire [11:0] lut_wr_rgb = {lut_red[7:4], lut_green[7:4], pwdata[7:4]};

    pfcl_lut #(.ENTRIES(256), .IW(LUT_IW)) u_lcd_lut (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(lut_data_wr && !lut_sel[`PFCL_LUT_CRT_BIT]),
        .wr_idx(lut_idx),
        .wr_rgb(lut_wr_rgb),
        .rd_idx(pix_idx),
        .rd_rgb(lcd_rgb),
        .sw_idx(lut_idx),
        .sw_rgb(lcd_sw_rgb)
    );

    pfcl_lut #(.ENTRIES(256), .IW(LUT_IW)) u_crt_lut (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(lut_data_wr && (lut_sel != 2'h2)),
        .wr_idx(lut_idx),
        .wr_rgb(lut_wr_rgb),
        .rd_idx(pix_idx),
        .rd_rgb(crt_rgb),
        .sw_idx(lut_idx),
        .sw_rgb(crt_sw_rgb)
    );

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    wire [11:0] sw_rgb = lut_sel[`PFCL_LUT_CRT_BIT] ? crt_sw_rgb : lcd_sw_rgb;
    reg [3:0] lut_rd_nib;
    always @* begin
        case (lut_bank)
            2'h0: lut_rd_nib = sw_rgb[11:8];
            2'h1: lut_rd_nib = sw_rgb[7:4];
            default: lut_rd_nib = sw_rgb[3:0];
        endcase
    end

    reg [31:0] next_prdata;
    always @* begin
        case (paddr)
            `PFCL_PANEL_CFG_ADDR: next_prdata = {24'h000000, panel_cfg};
            `PFCL_DISP_MODE_ADDR: next_prdata = {24'h000000, disp_mode};
            `PFCL_FMT_ADDR: next_prdata = {24'h000000, fmt};
            `PFCL_LUT_SEL_ADDR: next_prdata = {30'h00000000, lut_sel};
            `PFCL_LUT_IDX_ADDR: next_prdata = {24'h000000, lut_idx};
            `PFCL_LUT_DATA_ADDR: next_prdata = {24'h000000, lut_rd_nib, 4'h0};
            `PFCL_BUF_ADDR_ADDR: next_prdata = {{(32-BUF_AW){1'b0}}, host_addr};
            `PFCL_BUF_DATA_ADDR: next_prdata = {24'h000000, mem_host[host_addr[1:0]]};
            `PFCL_STATUS_ADDR: next_prdata = {28'h0000000, lut_bypass, pix_mono, lut_bank};
            default: next_prdata = 32'h00000000;
        endcase
    end

    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            panel_cfg <= `PFCL_CFG_RESET;
            disp_mode <= `PFCL_CFG_RESET;
            fmt <= `PFCL_FMT_RESET;
            lut_sel <= 2'h0;
            lut_idx <= {LUT_IW{1'b0}};
            lut_bank <= 2'h0;
            lut_red <= 8'h00;
            lut_green <= 8'h00;
            host_addr <= {BUF_AW{1'b0}};
            host_wdata <= 8'h00;
            host_wr <= 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                mem_host[k] <= 8'h00;
            end
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known_addr(paddr);
            if (psel && !penable) begin
                prdata <= next_prdata;
            end
            host_wr <= 1'b0;
            if (wr_acc) begin
                case (paddr)
                    `PFCL_PANEL_CFG_ADDR: panel_cfg <= pwdata[7:0];
                    `PFCL_DISP_MODE_ADDR: disp_mode <= pwdata[7:0];
                    `PFCL_FMT_ADDR: fmt <= pwdata[7:0];
                    `PFCL_LUT_SEL_ADDR: lut_sel <= pwdata[1:0];
                    `PFCL_LUT_IDX_ADDR: begin
                        lut_idx <= pwdata[LUT_IW-1:0];
                        lut_bank <= 2'h0;
                    end
                    `PFCL_BUF_ADDR_ADDR: host_addr <= pwdata[BUF_AW-1:0];
                    `PFCL_BUF_DATA_ADDR: begin
                        // Whole byte is written; the host masks nibbles itself
                        mem_host[host_addr[1:0]] <= pwdata[7:0];
                        host_wdata <= pwdata[7:0];
                        host_wr <= 1'b1;
                    end
                    default: ;
                endcase
            end
            if ((wr_acc || rd_acc) && paddr == `PFCL_LUT_DATA_ADDR) begin
                if (wr_acc && lut_bank == 2'h0) begin
                    lut_red <= pwdata[7:0];
                end
                if (wr_acc && lut_bank == 2'h1) begin
                    lut_green <= pwdata[7:0];
                end
                if (lut_bank == 2'h2) begin
                    lut_bank <= 2'h0;
                    lut_idx <= lut_idx + 1'b1;
                end else begin
                    lut_bank <= lut_bank + 2'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // Fetch and unpack
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_LOW = 2'h1;
    localparam ST_HIGH = 2'h2;
    localparam ST_EMIT = 2'h3;

    reg [1:0] state;
    reg [7:0] byte_lo;
    reg [15:0] word;
    reg nib_second;
    reg wide;
    reg fetch_wait;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            fetch_addr <= {BUF_AW{1'b0}};
            fetch_req <= 1'b0;
            fetch_wait <= 1'b0;
            byte_lo <= 8'h00;
            word <= 16'h0000;
            nib_second <= 1'b0;
            wide <= 1'b0;
            pix_idx <= {LUT_IW{1'b0}};
        end else begin
            fetch_req <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (enable) begin
                        fetch_req <= 1'b1;
                        fetch_wait <= 1'b1;
                        wide <= depth[1];
                        state <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (fetch_valid && fetch_wait) begin
                        fetch_wait <= 1'b0;
                        fetch_addr <= fetch_addr + 1'b1;
                        byte_lo <= fetch_data;
                        if (wide) begin
                            fetch_req <= 1'b1;
                            fetch_wait <= 1'b1;
                            state <= ST_HIGH;
                        end else begin
                            word <= {8'h00, fetch_data};
                            nib_second <= 1'b0;
                            state <= ST_EMIT;
                        end
                    end
                end
                ST_HIGH: begin
                    if (fetch_valid && fetch_wait) begin
                        fetch_wait <= 1'b0;
                        fetch_addr <= fetch_addr + 1'b1;
                        word <= {fetch_data, byte_lo};
                        state <= ST_EMIT;
                    end
                end
                ST_EMIT: begin
                    if (pix_ready) begin
                        if (depth == `PFCL_DEPTH_4 && !nib_second) begin
                            nib_second <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
            if (depth == `PFCL_DEPTH_4) begin
                // Upper nibble first, only the first 16 entries reachable
                pix_idx <= {4'h0, nib_second ? word[3:0] : word[7:4]};
            end else begin
                pix_idx <= word[7:0];
            end
        end
    end

    // ----------------------------------------
    // Colour formation
    // ----------------------------------------
    // Index settles one cycle after the nibble choice, so emission waits a cycle
    reg emit_d;
    wire direct = depth[1];
    wire cut = !dither && (panel == `PFCL_PANEL_PASSIVE);
    reg [5:0] d_r;
    reg [5:0] d_g;
    reg [5:0] d_b;
    always @* begin
        if (depth == `PFCL_DEPTH_15) begin
            d_r = widen5(word[14:10]);
            d_g = widen5(word[9:5]);
            d_b = widen5(word[4:0]);
        end else begin
            d_r = widen5(word[15:11]);
            d_g = word[10:5];
            d_b = widen5(word[4:0]);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emit_d <= 1'b0;
            pix_valid <= 1'b0;
            lcd_red <= 6'h00;
            lcd_green <= 6'h00;
            lcd_blue <= 6'h00;
            crt_red <= 6'h00;
            crt_green <= 6'h00;
            crt_blue <= 6'h00;
            lut_bypass <= 1'b0;
            pix_mono <= 1'b0;
        end else begin
            emit_d <= (state == ST_EMIT) && pix_ready;
            pix_valid <= emit_d;
            lut_bypass <= direct;
            pix_mono <= !color;
            if (emit_d) begin
                if (direct) begin
                    lcd_red <= color ? limit(d_r, cut) : 6'h00;
                    lcd_green <= limit(d_g, cut);
                    lcd_blue <= color ? limit(d_b, cut) : 6'h00;
                end else begin
                    lcd_red <= color ? widen4(lcd_rgb[11:8]) : 6'h00;
                    lcd_green <= widen4(lcd_rgb[7:4]);
                    lcd_blue <= color ? widen4(lcd_rgb[3:0]) : 6'h00;
                end
                // CRT always gets full RGB
                crt_red <= direct ? d_r : widen4(crt_rgb[11:8]);
                crt_green <= direct ? d_g : widen4(crt_rgb[7:4]);
                crt_blue <= direct ? d_b : widen4(crt_rgb[3:0]);
            end
        end
    end
endmodule

// ---- verif/pfcl_top_asserts.sv ----
// Port assertions for the pixel format and colour look-up block
`timescale 1ns/1ns
`include "pfcl_map.vh"
module pfcl_top_asserts (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Pixel side
    input wire pix_valid,
    input wire [5:0] lcd_red,
    input wire [5:0] lcd_green,
    input wire [5:0] lcd_blue,
    input wire lut_bypass,
    input wire pix_mono
);
    // ----
    // Shadow of the mode registers
    // ----
    logic [3:0] fmt;
    logic color, dither, acc, mapped, lim;
    assign acc = psel && penable && pready;
    assign mapped = paddr == `PFCL_PANEL_CFG_ADDR || paddr == `PFCL_DISP_MODE_ADDR
        || (paddr >= `PFCL_FMT_ADDR && paddr <= `PFCL_STATUS_ADDR && paddr[1:0] == 2'h0);
    // Only bypassed depths on a passive panel without dither are cut to 4 bits
    assign lim = fmt[3:2] == `PFCL_PANEL_PASSIVE && !dither && fmt[1];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt <= 4'h0;
            color <= 1'b0;
            dither <= 1'b0;
        end else if (acc && pwrite) begin
            case (paddr)
                `PFCL_FMT_ADDR: fmt <= pwdata[3:0];
                `PFCL_PANEL_CFG_ADDR: color <= pwdata[`PFCL_COLOR_BIT];
                `PFCL_DISP_MODE_ADDR: dither <= pwdata[`PFCL_DITHER_BIT];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("no pready in access cycle");
    property p_err_map;
        acc |-> pslverr == !mapped;
    endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr does not match address map");
    property p_err_zero;
        acc && !pwrite && !mapped |-> prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("unmapped read data not zero");
    property p_bypass;
        pix_valid |-> lut_bypass == fmt[1];
    endproperty
    a_bypass: assert property (p_bypass) else $error("table bypass wrong for depth");
    property p_mono;
        pix_valid |-> pix_mono == !color;
    endproperty
    a_mono: assert property (p_mono) else $error("mono flag wrong for panel select");
    property p_gray;
        pix_valid && !color |-> lcd_red == 6'h00 && lcd_blue == 6'h00;
    endproperty
    a_gray: assert property (p_gray) else $error("gray pixel has red or blue");
    property p_cut;
        pix_valid && color && lim |-> lcd_red[1:0] == lcd_red[5:4] && lcd_blue[1:0] == lcd_blue[5:4];
    endproperty
    a_cut: assert property (p_cut) else $error("passive colour not cut to 4 bits");
    property p_gray_cut;
        pix_valid && lim |-> lcd_green[1:0] == lcd_green[5:4];
    endproperty
    a_gray_cut: assert property (p_gray_cut) else $error("undithered green not cut to 4 bits");
endmodule

bind pfcl_top pfcl_top_asserts i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .lcd_red(lcd_red), .lcd_green(lcd_green), .lcd_blue(lcd_blue),
    .lut_bypass(lut_bypass), .pix_mono(pix_mono)
);

// ---- verif/pfcl_far_end.sv ----
// Far-side model: display buffer byte source and pixel sink
`timescale 1ns/1ns
module pfcl_far_end (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Buffer read port
    input wire [18:0] fetch_addr,
    input wire fetch_req,
    output logic [7:0] fetch_data,
    output logic fetch_valid,
    // Pixel sink and pacing
    output logic pix_ready,
    input wire slow
);
    logic [7:0] sent [$];
    logic [18:0] addr;
    logic [1:0] wait_cnt, tick;
    logic busy;
    logic [7:0] val;
    assign val = addr[7:0] * 8'h35 + 8'h1B;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_valid <= 1'b0;
            fetch_data <= 8'h00;
            busy <= 1'b0;
            wait_cnt <= 2'h0;
            tick <= 2'h0;
            pix_ready <= 1'b0;
            addr <= 19'h0;
        end else begin
            tick <= tick + 2'h1;
            pix_ready <= !slow || tick[1];
            fetch_valid <= 1'b0;
            // Released data is scrambled so a stale byte never looks valid
            fetch_data <= ~fetch_data;
            if (fetch_req) begin
                busy <= 1'b1;
                addr <= fetch_addr;
                wait_cnt <= slow ? 2'h3 : 2'h0;
            end else if (busy && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (busy) begin
                busy <= 1'b0;
                fetch_valid <= 1'b1;
                fetch_data <= val;
                sent.push_back(val);
            end
        end
    end
endmodule

// ---- verif/pfcl_top_tb.sv ----
// Self-checking bench for the pixel format and colour look-up block
`timescale 1ns/1ns
`include "pfcl_map.vh"
module pfcl_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fetch_req, fetch_valid;
    logic pix_ready, pix_valid, lut_bypass, pix_mono, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [18:0] fetch_addr;
    logic [7:0] fetch_data;
    logic [5:0] lcd_red, lcd_green, lcd_blue, crt_red, crt_green, crt_blue;
    logic [3:0] lr [256], lg [256], lb [256];
    logic [35:0] pix_q [$];
    logic err;
    int n_fail = 0;
    int tests_run = 0;
    localparam logic [1:0] PAS = `PFCL_PANEL_PASSIVE;
    pfcl_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fetch_addr(fetch_addr), .fetch_req(fetch_req), .fetch_data(fetch_data), .fetch_valid(fetch_valid),
        .pix_ready(pix_ready), .pix_valid(pix_valid), .lcd_red(lcd_red), .lcd_green(lcd_green),
        .lcd_blue(lcd_blue), .crt_red(crt_red), .crt_green(crt_green), .crt_blue(crt_blue),
        .lut_bypass(lut_bypass), .pix_mono(pix_mono));
    pfcl_far_end i_far (.pclk(pclk), .presetn(presetn), .fetch_addr(fetch_addr), .fetch_req(fetch_req),
        .fetch_data(fetch_data), .fetch_valid(fetch_valid), .pix_ready(pix_ready), .slow(slow));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Sampled mid-cycle so the pulse is seen once and never races its edge
    always @(negedge pclk) begin
        if (pix_valid === 1'b1) pix_q.push_back({lcd_red, lcd_green, lcd_blue, crt_red, crt_green, crt_blue});
    end
    // ----
    // Bus and compare helpers
    // ----
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) chk(32'h0, 32'h1);
    endtask
    function automatic logic [11:0] fx(input logic [5:0] v, input logic [5:0] mk, input logic cut);
        fx = cut ? {v[5:2], v[5:4], 6'h3F} : {v, mk};
    endfunction
    // Expected colour in the upper 18 bits, compare mask in the lower 18
    function automatic logic [35:0] ex(input logic [1:0] dep, input logic [15:0] w, input logic [11:0] e,
        input logic col, input logic cut);
        logic [11:0] r, g, b;
        r = {e[11:8], 2'h0, 6'h3C};
        g = {e[7:4], 2'h0, 6'h3C};
        b = {e[3:0], 2'h0, 6'h3C};
        if (dep[1]) begin
            g = dep[0] ? fx(w[10:5], 6'h3F, cut) : fx({w[9:5], 1'b0}, 6'h3E, cut);
            r = fx({dep[0] ? w[15:11] : w[14:10], 1'b0}, 6'h3E, cut);
            b = fx({w[4:0], 1'b0}, 6'h3E, cut);
        end
        if (!col) begin
            r = 12'h03F;
            b = 12'h03F;
        end
        ex = {r[11:6], g[11:6], b[11:6], r[5:0], g[5:0], b[5:0]};
    endfunction
    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        apb(0, `PFCL_FMT_ADDR, 0);
        chk({err, q}, {1'b0, 24'h0, `PFCL_FMT_RESET});
        apb(0, `PFCL_PANEL_CFG_ADDR, 0);
        chk({err, q}, {1'b0, 24'h0, `PFCL_CFG_RESET});
        apb(1, 12'h0FC, 32'h5A);
        chk(err, 1);
        apb(0, 12'h0FC, 0);
        chk({err, q}, {1'b1, 32'h0});
        apb(1, `PFCL_BUF_ADDR_ADDR, 32'h5);
        apb(1, `PFCL_BUF_DATA_ADDR, 32'hA7);
        apb(0, `PFCL_BUF_DATA_ADDR, 0);
        chk(q, 32'hA7);
        apb(1, `PFCL_BUF_DATA_ADDR, {24'h0, q[7:4], 4'h3});
        apb(0, `PFCL_BUF_DATA_ADDR, 0);
        chk(q, 32'hA3);
        apb(0, `PFCL_BUF_ADDR_ADDR, 0);
        chk(q, 32'h5);
        $display("register test done");
    endtask
    task automatic t_lut;
        apb(1, `PFCL_LUT_SEL_ADDR, 0);
        apb(1, `PFCL_LUT_IDX_ADDR, 0);
        for (int i = 0; i < 256; i++) begin
            lr[i] = i[3:0] ^ i[7:4];
            lg[i] = i[3:0] + 4'h5 + i[7:4];
            lb[i] = ~i[3:0] ^ {i[5:4], i[7:6]};
            apb(1, `PFCL_LUT_DATA_ADDR, {24'h0, lr[i], 4'h0});
            apb(1, `PFCL_LUT_DATA_ADDR, {24'h0, lg[i], 4'h0});
            apb(1, `PFCL_LUT_DATA_ADDR, {24'h0, lb[i], 4'h0});
        end
        apb(1, `PFCL_LUT_IDX_ADDR, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            apb(0, `PFCL_LUT_DATA_ADDR, 0);
            chk({q[31:4], 4'h0}, {24'h0, i % 3 == 0 ? lr[i / 3 * 1 + 255 & 255] :
                i % 3 == 1 ? lg[i / 3 + 255 & 255] : lb[i / 3 + 255 & 255], 4'h0});
        end
        apb(1, `PFCL_LUT_SEL_ADDR, 1);
        apb(1, `PFCL_LUT_IDX_ADDR, 3);
        apb(1, `PFCL_LUT_DATA_ADDR, {24'h0, ~lr[3], 4'h0});
        apb(1, `PFCL_LUT_DATA_ADDR, {24'h0, lg[3], 4'h0});
        apb(1, `PFCL_LUT_DATA_ADDR, {24'h0, lb[3], 4'h0});
        apb(1, `PFCL_LUT_SEL_ADDR, 2);
        apb(1, `PFCL_LUT_IDX_ADDR, 3);
        apb(0, `PFCL_LUT_DATA_ADDR, 0);
        chk({q[31:4], 4'h0}, {24'h0, lr[3], 4'h0});
        apb(1, `PFCL_LUT_SEL_ADDR, 1);
        apb(1, `PFCL_LUT_IDX_ADDR, 3);
        apb(0, `PFCL_LUT_DATA_ADDR, 0);
        chk({q[31:4], 4'h0}, {24'h0, ~lr[3], 4'h0});
        $display("table test done");
    endtask
    task automatic t_mode(input logic [1:0] dep, input logic [1:0] pan, input logic col, dit, sl);
        logic [15:0] w;
        logic [7:0] ix;
        logic [35:0] le, ce;
        logic cut;
        int n;
        cut = pan == PAS && !dit;
        slow <= sl;
        apb(1, `PFCL_FMT_ADDR, {28'h0, pan, dep});
        apb(1, `PFCL_PANEL_CFG_ADDR, {29'h0, col, 2'h0});
        pix_q.delete();
        i_far.sent.delete();
        apb(1, `PFCL_DISP_MODE_ADDR, {30'h0, dit, 1'b1});
        n = 0;
        while (pix_q.size() < 12 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        apb(1, `PFCL_DISP_MODE_ADDR, {30'h0, dit, 1'b0});
        repeat (20) @(posedge pclk);
        chk(pix_q.size() >= 12, 1);
        for (int k = 0; k < 12; k++) begin
            if (dep[1]) w = {i_far.sent[2 * k + 1], i_far.sent[2 * k]};
            ix = dep[0] ? i_far.sent[k] : {4'h0, k[0] ? i_far.sent[k / 2][3:0] : i_far.sent[k / 2][7:4]};
            le = ex(dep, w, {lr[ix], lg[ix], lb[ix]}, col, cut);
            // The CRT table differs from the LCD one only in the red of entry 3
            ce = ex(dep, w, {ix == 8'h03 ? ~lr[3] : lr[ix], lg[ix], lb[ix]}, 1'b1, 1'b0);
            chk(pix_q[k][35:18] & le[17:0], le[35:18] & le[17:0]);
            chk(pix_q[k][17:0] & ce[17:0], ce[35:18] & ce[17:0]);
        end
        apb(0, `PFCL_STATUS_ADDR, 0);
        chk(q[31:2], {28'h0, dep[1], !col});
        $display("mode test %0d %0d %0d %0d done", dep, pan, col, dit);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        slow = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_lut();
        t_mode(`PFCL_DEPTH_4, PAS, 1, 0, 1);
        t_mode(`PFCL_DEPTH_4, PAS, 0, 0, 0);
        t_mode(`PFCL_DEPTH_8, `PFCL_PANEL_ACTIVE, 1, 0, 1);
        t_mode(`PFCL_DEPTH_8, PAS, 0, 1, 0);
        t_mode(`PFCL_DEPTH_15, `PFCL_PANEL_ACTIVE, 1, 0, 0);
        t_mode(`PFCL_DEPTH_15, PAS, 1, 0, 1);
        t_mode(`PFCL_DEPTH_15, PAS, 1, 1, 0);
        t_mode(`PFCL_DEPTH_15, PAS, 0, 1, 0);
        t_mode(`PFCL_DEPTH_15, PAS, 0, 0, 1);
        t_mode(`PFCL_DEPTH_16, `PFCL_PANEL_CRT, 1, 0, 1);
        t_mode(`PFCL_DEPTH_16, PAS, 1, 0, 0);
        t_mode(`PFCL_DEPTH_16, PAS, 0, 1, 1);
        t_mode(`PFCL_DEPTH_16, PAS, 0, 0, 0);
        complete_run();
    end
    // Whole run needs well under 60000 cycles; give up there
    initial begin
        #3000000;
        n_fail++;
        complete_run();
    end
endmodule
